// ---- design/pcm_top.sv ----
`timescale 1ns/100ps
`include "pcm_cfg.svh"

// Behaviour
// - Main clock runs an 8-bit prescaler; each domain picks any tap or undivided.
// - CPU clock rate is main rate divided by two to the CPU divide field.
// - AHB clock always runs at the CPU clock rate.
// - Select writes never halt peripherals; new dividers apply together on one edge.
// - Clock ready flag reads zero from a select write until it takes effect.
// - With its enable set, clock ready raises the interrupt request.
// - Each AHB and APB peripheral clock has its own mask bit, one enables.
// - Masks reset to the fixed default enabled and disabled peripheral set.
// - A module with its bus clock masked off cannot be read or written.
// - Masking this block or its bridge locks the masks until system reset.
// - Power-on records its cause, selects undivided main clock, CPU waits for clock ready.
// - The block is always enabled and has no disable or own reset.
// - Reset cause register holds for software the latest reset source not weaker than the reset still being held.
// - Power resets clear everything; external spares always-on; user spares debug too.
// - Reset pin held low generates an external reset for as long as low.
// - Power-on detector holds the whole system in reset until supply is stable.
// - CPU software reset request and watchdog reset are accepted sources.
// - Wait-for-interrupt enters sleep; idle field and deep-sleep bit pick the level.
// - Idle 0 wakes on APB, AHB, async; idle 1 APB, async; idle 2 async.
// - Standby stops sources, sets regulator low power, wakes only on async.
// - Idle 0 stops CPU; idle 1 also AHB; idle 2 also APB clocks.
// - In standby this logic is frozen and returns active on any async interrupt.
// - Writing one to the clock ready flag bit clears it.
module pcm_top #(
  parameter int PRESCALE_W = 8
) (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // Interrupt
  output logic irq_o,
  // Domain clock strobes
  output logic cpu_clk_en_o,
  output logic ahb_clk_en_o,
  output logic [2:0] apb_clk_en_o,
  output logic [31:0] ahb_periph_en_o,
  output logic [31:0] apba_periph_en_o,
  output logic [31:0] apbb_periph_en_o,
  output logic [31:0] apbc_periph_en_o,
  // Main clock status from the generic clock controller
  input wire logic main_clk_ready_i,
  // Reset sources
  input wire logic core_brownout_reset_i,
  input wire logic io_brownout_reset_i,
  input wire logic reset_pin_b_i,
  input wire logic watchdog_reset_i,
  input wire logic cpu_software_reset_request_i,
  // Reset outputs
  output logic power_reset_o,
  output logic debug_reset_o,
  output logic system_reset_o,
  // Sleep control
  input wire logic wait_for_interrupt_instr_i,
  input wire logic cpu_deep_sleep_bit_i,
  input wire logic wake_async_i,
  input wire logic wake_apb_i,
  input wire logic wake_ahb_i,
  output logic regulator_low_power_o,
  output logic clock_sources_stop_o
);

  localparam logic [7:0] HOLD_CYC = 8'(`PCM_RST_HOLD_CYC);
  localparam int TOP = PRESCALE_W - 1;

  // Asynchronous inputs: [0] core brown-out, [1] io brown-out, [2] pin, [3] ready, [4] wake.
  localparam logic [4:0] SYNC_RST = 5'h04;
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic bodc_s;
  logic bodi_s;
  logic pin_b_s;
  logic clk_rdy_s;
  logic wake_s;

  logic [PRESCALE_W-1:0] taps;
  pcm_pkg::pcm_state_e st_reg;
  logic [`PCM_IDLE_W-1:0] idle_reg;
  logic [`PCM_IDLE_W-1:0] idle_lvl_reg;
  logic [3:0][`PCM_DIV_W-1:0] div_new_reg;
  logic [3:0][`PCM_DIV_W-1:0] div_cur_reg;
  logic pending_reg;
  logic flag_reg;
  logic inten_reg;
  logic [31:0] ahb_mask_reg;
  logic [31:0] apba_mask_reg;
  logic [31:0] apbb_mask_reg;
  logic [31:0] apbc_mask_reg;
  logic [7:0] cause_reg;
  logic [7:0] hold_reg;
  pcm_pkg::pcm_rkind_e kind_reg;
  pcm_pkg::pcm_rkind_e evt_kind;
  pcm_pkg::pcm_rkind_e eff_kind;
  logic [7:0] evt_cause;
  logic take_evt;
  logic in_rst;
  logic sys_rst_reg;
  logic dbg_rst_reg;
  logic pwr_rst_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic lock;
  logic wr;
  logic sel_wr;
  logic [1:0] sel_idx;
  logic apply_now;
  logic cpu_tick;
  logic ahb_run;
  logic apb_run;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return wr && (a == ofs);
  endfunction

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end else begin
      sync1_reg <= {wake_async_i, main_clk_ready_i, reset_pin_b_i,
                    io_brownout_reset_i, core_brownout_reset_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign bodc_s = sync2_reg[0];
  assign bodi_s = sync2_reg[1];
  assign pin_b_s = sync2_reg[2];
  assign clk_rdy_s = sync2_reg[3];
  assign wake_s = sync2_reg[4];

  // The prescaler is frozen in standby and runs in every other state.
  pcm_prescaler #(.W(PRESCALE_W)) u_prescaler (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .run_i(st_reg != pcm_pkg::PCM_ST_STANDBY),
    .taps_o(taps)
  );

  // Reset sources, the strongest one present in a cycle wins.
  always_comb begin
    evt_kind = pcm_pkg::PCM_RK_NONE;
    evt_cause = 8'h00;
    if (cpu_software_reset_request_i) begin
      evt_kind = pcm_pkg::PCM_RK_USER;
      evt_cause = `PCM_CAUSE_SW;
    end
    if (watchdog_reset_i) begin
      evt_kind = pcm_pkg::PCM_RK_USER;
      evt_cause = `PCM_CAUSE_WDT;
    end
    if (!pin_b_s) begin
      evt_kind = pcm_pkg::PCM_RK_EXT;
      evt_cause = `PCM_CAUSE_EXT;
    end
    if (bodi_s) begin
      evt_kind = pcm_pkg::PCM_RK_POWER;
      evt_cause = `PCM_CAUSE_BOD_IO;
    end
    if (bodc_s) begin
      evt_kind = pcm_pkg::PCM_RK_POWER;
      evt_cause = `PCM_CAUSE_BOD_CORE;
    end
  end

  assign take_evt = (evt_kind != pcm_pkg::PCM_RK_NONE) &&
                    (hold_reg == 8'h00 || evt_kind >= kind_reg);
  assign eff_kind = take_evt ? evt_kind : kind_reg;
  assign in_rst = (evt_kind != pcm_pkg::PCM_RK_NONE) || (hold_reg != 8'h00);

  // The power-on detector is the block's own reset, so it alone clears the cause.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_reg <= HOLD_CYC;
      kind_reg <= pcm_pkg::PCM_RK_POWER;
      cause_reg <= `PCM_CAUSE_POR;
    end else if (evt_kind != pcm_pkg::PCM_RK_NONE) begin
      hold_reg <= HOLD_CYC;
      if (take_evt) begin
        kind_reg <= evt_kind;
        cause_reg <= evt_cause;
      end
    end else if (hold_reg != 8'h00) begin
      hold_reg <= hold_reg - 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sys_rst_reg <= 1'b1;
      dbg_rst_reg <= 1'b1;
      pwr_rst_reg <= 1'b1;
    end else begin
      sys_rst_reg <= in_rst;
      dbg_rst_reg <= in_rst && (eff_kind != pcm_pkg::PCM_RK_USER);
      pwr_rst_reg <= in_rst && (eff_kind == pcm_pkg::PCM_RK_POWER);
    end
  end

  assign system_reset_o = sys_rst_reg;
  assign debug_reset_o = dbg_rst_reg;
  assign power_reset_o = pwr_rst_reg;

  // Losing this block's bus clock or its bridge clock shuts its register port.
  assign lock = !apba_mask_reg[`PCM_BIT_APBA_SELF] || !ahb_mask_reg[`PCM_BIT_AHB_BRIDGE];
  assign wr = reg_we_i && !lock;
  assign sel_wr = wr && (reg_addr_i >= `PCM_OFS_CPU_CLOCK_SELECT) &&
                  (reg_addr_i < (`PCM_OFS_CPU_CLOCK_SELECT + `PCM_SEL_COUNT));
  assign sel_idx = 2'(reg_addr_i - `PCM_OFS_CPU_CLOCK_SELECT);
  // New dividers wait for the common tick of all taps, so every domain restarts aligned.
  assign apply_now = pending_reg && taps[TOP] && !sel_wr;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_new_reg <= '0;
      div_cur_reg <= '0;
      pending_reg <= 1'b0;
    end else if (sys_rst_reg) begin
      div_new_reg <= '0;
      div_cur_reg <= '0;
      pending_reg <= 1'b0;
    end else if (sel_wr) begin
      div_new_reg[sel_idx] <= reg_wdata_i[`PCM_DIV_W-1:0];
      pending_reg <= 1'b1;
    end else if (apply_now) begin
      div_cur_reg <= div_new_reg;
      pending_reg <= 1'b0;
    end
  end

  // The ready event wins over a clear written in the same cycle.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_reg <= 1'b1;
    end else if (sys_rst_reg) begin
      flag_reg <= 1'b1;
    end else if (sel_wr) begin
      flag_reg <= 1'b0;
    end else if (apply_now) begin
      flag_reg <= 1'b1;
    end else if (hit(reg_addr_i, `PCM_OFS_INTERRUPT_FLAG_REG) && reg_wdata_i[`PCM_BIT_CLOCK_READY_FLAG]) begin
      flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      inten_reg <= 1'b0;
    end else if (sys_rst_reg) begin
      inten_reg <= 1'b0;
    end else if (hit(reg_addr_i, `PCM_OFS_INTERRUPT_ENABLE_SET_REG) && reg_wdata_i[`PCM_BIT_CLOCK_READY_FLAG]) begin
      inten_reg <= 1'b1;
    end else if (hit(reg_addr_i, `PCM_OFS_INTENCLR) && reg_wdata_i[`PCM_BIT_CLOCK_READY_FLAG]) begin
      inten_reg <= 1'b0;
    end
  end

  assign irq_o = flag_reg && inten_reg;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ahb_mask_reg <= `PCM_RST_AHBMASK;
      apba_mask_reg <= `PCM_RST_APBAMASK;
      apbb_mask_reg <= `PCM_RST_APBBMASK;
      apbc_mask_reg <= `PCM_RST_APBCMASK;
    end else if (sys_rst_reg) begin
      ahb_mask_reg <= `PCM_RST_AHBMASK;
      apba_mask_reg <= `PCM_RST_APBAMASK;
      apbb_mask_reg <= `PCM_RST_APBBMASK;
      apbc_mask_reg <= `PCM_RST_APBCMASK;
    end else begin
      if (hit(reg_addr_i, `PCM_OFS_AHBMASK)) begin
        ahb_mask_reg <= reg_wdata_i;
      end
      if (hit(reg_addr_i, `PCM_OFS_APBAMASK)) begin
        apba_mask_reg <= reg_wdata_i;
      end
      if (hit(reg_addr_i, `PCM_OFS_APBBMASK)) begin
        apbb_mask_reg <= reg_wdata_i;
      end
      if (hit(reg_addr_i, `PCM_OFS_APBCMASK)) begin
        apbc_mask_reg <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_reg <= '0;
    end else if (sys_rst_reg) begin
      idle_reg <= '0;
    end else if (hit(reg_addr_i, `PCM_OFS_SLEEP)) begin
      idle_reg <= reg_wdata_i[`PCM_IDLE_W-1:0];
    end
  end

  // Sleep controller.  There is no enable: the block cannot be switched off.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= pcm_pkg::PCM_ST_BOOT;
      idle_lvl_reg <= '0;
    end else if (sys_rst_reg) begin
      st_reg <= pcm_pkg::PCM_ST_BOOT;
    end else begin
      case (st_reg)
        pcm_pkg::PCM_ST_BOOT: begin
          if (clk_rdy_s) begin
            st_reg <= pcm_pkg::PCM_ST_ACTIVE;
          end
        end
        pcm_pkg::PCM_ST_ACTIVE: begin
          if (wait_for_interrupt_instr_i) begin
            idle_lvl_reg <= idle_reg;
            st_reg <= cpu_deep_sleep_bit_i ? pcm_pkg::PCM_ST_STANDBY : pcm_pkg::PCM_ST_IDLE;
          end
        end
        pcm_pkg::PCM_ST_IDLE: begin
          if (wake_s || (idle_lvl_reg == 2'h0 && wake_ahb_i) ||
              (idle_lvl_reg <= 2'h1 && wake_apb_i)) begin
            st_reg <= pcm_pkg::PCM_ST_ACTIVE;
          end
        end
        pcm_pkg::PCM_ST_STANDBY: begin
          if (wake_s) begin
            st_reg <= pcm_pkg::PCM_ST_ACTIVE;
          end
        end
        default: begin
          st_reg <= pcm_pkg::PCM_ST_BOOT;
        end
      endcase
    end
  end

  // Levels above two behave as level two.
  assign ahb_run = (st_reg == pcm_pkg::PCM_ST_ACTIVE) || (st_reg == pcm_pkg::PCM_ST_BOOT) ||
                   (st_reg == pcm_pkg::PCM_ST_IDLE && idle_lvl_reg == 2'h0);
  assign apb_run = (st_reg != pcm_pkg::PCM_ST_STANDBY) &&
                   !(st_reg == pcm_pkg::PCM_ST_IDLE && idle_lvl_reg >= 2'h2);
  assign cpu_tick = taps[div_cur_reg[0]];
  assign cpu_clk_en_o = cpu_tick && (st_reg == pcm_pkg::PCM_ST_ACTIVE);
  assign ahb_clk_en_o = cpu_tick && ahb_run;
  assign regulator_low_power_o = (st_reg == pcm_pkg::PCM_ST_STANDBY);
  assign clock_sources_stop_o = (st_reg == pcm_pkg::PCM_ST_STANDBY);

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      apb_clk_en_o[i] = taps[div_cur_reg[i+1]] && apb_run;
    end
  end

  assign ahb_periph_en_o = {32{ahb_clk_en_o}} & ahb_mask_reg;
  assign apba_periph_en_o = {32{apb_clk_en_o[0]}} & apba_mask_reg;
  assign apbb_periph_en_o = {32{apb_clk_en_o[1]}} & apbb_mask_reg;
  assign apbc_periph_en_o = {32{apb_clk_en_o[2]}} & apbc_mask_reg;

  always_comb begin
    rdata_next = 32'h00000000;
    case (reg_addr_i)
      `PCM_OFS_SLEEP: rdata_next = 32'(idle_reg);
      `PCM_OFS_CPU_CLOCK_SELECT: rdata_next = 32'(div_new_reg[0]);
      8'h09: rdata_next = 32'(div_new_reg[1]);
      8'h0a: rdata_next = 32'(div_new_reg[2]);
      8'h0b: rdata_next = 32'(div_new_reg[3]);
      `PCM_OFS_AHBMASK: rdata_next = ahb_mask_reg;
      `PCM_OFS_APBAMASK: rdata_next = apba_mask_reg;
      `PCM_OFS_APBBMASK: rdata_next = apbb_mask_reg;
      `PCM_OFS_APBCMASK: rdata_next = apbc_mask_reg;
      `PCM_OFS_INTENCLR: rdata_next = 32'(inten_reg);
      `PCM_OFS_INTERRUPT_ENABLE_SET_REG: rdata_next = 32'(inten_reg);
      `PCM_OFS_INTERRUPT_FLAG_REG: rdata_next = 32'(flag_reg);
      `PCM_OFS_RESET_CAUSE_REG: rdata_next = 32'(cause_reg);
      default: rdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_reg <= 32'h00000000;
    end else if (reg_re_i && !lock) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  assign reg_rdata_o = rdata_reg;

  sequence s_enter_idle;
    st_reg == pcm_pkg::PCM_ST_ACTIVE && wait_for_interrupt_instr_i &&
    !cpu_deep_sleep_bit_i && idle_reg != 2'h0 && !sys_rst_reg;
  endsequence

  sequence s_enter_standby;
    st_reg == pcm_pkg::PCM_ST_ACTIVE && wait_for_interrupt_instr_i &&
    cpu_deep_sleep_bit_i && !sys_rst_reg;
  endsequence

  a_clock_ready_flag_while_pending: assert property (pending_reg |-> !flag_reg)
    else $error("Clock ready flag high while a divider change is pending.");

  a_apply_all_domains: assert property (apply_now && !sys_rst_reg |=>
    div_cur_reg == $past(div_new_reg) && flag_reg && !pending_reg)
    else $error("Divider settings not applied together.");

  a_irq_on_ready: assert property (apply_now && inten_reg && !reg_we_i && !sys_rst_reg
    |=> irq_o)
    else $error("Clock ready did not raise the interrupt.");

  // A select write or a sleep entry in the first cycle may legally change the next tick.
  a_cpu_half_rate: assert property (cpu_clk_en_o && div_cur_reg[0] == 3'h1 &&
    !pending_reg && !sys_rst_reg && !reg_we_i && !wait_for_interrupt_instr_i |=>
    !cpu_clk_en_o ##1 cpu_tick)
    else $error("CPU strobe does not follow divide by two.");

  a_ahb_with_cpu: assert property (cpu_clk_en_o |-> ahb_clk_en_o)
    else $error("AHB strobe missing beside CPU strobe.");

  a_mask_locked: assert property (lock && !sys_rst_reg |=> $stable(apba_mask_reg) &&
    $stable(ahb_mask_reg))
    else $error("Gate masks changed while locked.");

  a_idle_stops_clk: assert property (s_enter_idle |=> st_reg == pcm_pkg::PCM_ST_IDLE &&
    !ahb_clk_en_o && !cpu_clk_en_o)
    else $error("Idle entry left the CPU or AHB strobe running.");

  a_standby_entry: assert property (s_enter_standby |=> regulator_low_power_o &&
    clock_sources_stop_o && apb_clk_en_o == 3'h0)
    else $error("Standby entry did not stop clocks.");

  a_standby_wake: assert property (st_reg == pcm_pkg::PCM_ST_STANDBY && wake_s &&
    !sys_rst_reg && pin_b_s |=> st_reg == pcm_pkg::PCM_ST_ACTIVE)
    else $error("Standby did not wake on an asynchronous interrupt.");

  // A pin reset inside a held power reset keeps the stronger kind and cause.
  a_ext_reset: assert property (!pin_b_s && !bodc_s && !bodi_s &&
    (hold_reg == 8'h00 || kind_reg != pcm_pkg::PCM_RK_POWER) |=>
    system_reset_o && debug_reset_o && !power_reset_o && cause_reg == `PCM_CAUSE_EXT)
    else $error("Reset pin low did not give an external reset.");

endmodule // pcm_top

// ---- design/pcm_cfg.svh ----
`ifndef PCM_CFG_SVH
`define PCM_CFG_SVH

// Register byte offsets on the plain register port.
`define PCM_OFS_CTRL 8'h00
`define PCM_OFS_SLEEP 8'h01
`define PCM_OFS_CPU_CLOCK_SELECT 8'h08
`define PCM_SEL_COUNT 8'h04
`define PCM_OFS_AHBMASK 8'h14
`define PCM_OFS_APBAMASK 8'h18
`define PCM_OFS_APBBMASK 8'h1c
`define PCM_OFS_APBCMASK 8'h20
`define PCM_OFS_INTENCLR 8'h34
`define PCM_OFS_INTERRUPT_ENABLE_SET_REG 8'h35
`define PCM_OFS_INTERRUPT_FLAG_REG 8'h36
`define PCM_OFS_RESET_CAUSE_REG 8'h38

// Reset values of the clock gate masks.
`define PCM_RST_AHBMASK 32'h0000001f
`define PCM_RST_APBAMASK 32'h0000007f
`define PCM_RST_APBBMASK 32'h0000000f
`define PCM_RST_APBCMASK 32'h00010000

// Field positions.
`define PCM_BIT_APBA_SELF 1
`define PCM_BIT_AHB_BRIDGE 0
`define PCM_BIT_CLOCK_READY_FLAG 0
`define PCM_DIV_W 3
`define PCM_IDLE_W 2

// Reset cause encodings, one hot.
`define PCM_CAUSE_POR 8'h01
`define PCM_CAUSE_BOD_CORE 8'h02
`define PCM_CAUSE_BOD_IO 8'h04
`define PCM_CAUSE_EXT 8'h10
`define PCM_CAUSE_WDT 8'h20
`define PCM_CAUSE_SW 8'h40

// Timing.
`define PCM_CLK_MHZ 200
`define PCM_RST_HOLD_NS 100
`define PCM_RST_HOLD_CYC ((`PCM_RST_HOLD_NS * `PCM_CLK_MHZ + 999) / 1000)

`endif

// ---- design/pcm_pkg.sv ----
`include "pcm_cfg.svh"

package pcm_pkg;

  typedef enum logic [1:0] {PCM_ST_BOOT, PCM_ST_ACTIVE, PCM_ST_IDLE, PCM_ST_STANDBY} pcm_state_e;

  // Ordered by strength: a stronger reset kind is never downgraded while held.
  typedef enum logic [1:0] {PCM_RK_NONE, PCM_RK_USER, PCM_RK_EXT, PCM_RK_POWER} pcm_rkind_e;

  typedef logic [`PCM_DIV_W-1:0] pcm_div_t;

endpackage

// ---- design/pcm_prescaler.sv ----
`timescale 1ns/100ps
`include "pcm_cfg.svh"

module pcm_prescaler #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic run_i,
  // Taps: bit k pulses once every 2**k cycles while running
  output logic [W-1:0] taps_o
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  function automatic logic low_zero(input logic [W-1:0] v, input int k);
    logic [W-1:0] m;
    m = W'((1 << k) - 1);
    return (v & m) == '0;
  endfunction

  assign cnt_next = run_i ? W'(cnt_reg + 1'b1) : cnt_reg;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Taps are registered so that every domain strobe changes on the same edge.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      taps_o <= '0;
    end else begin
      for (int k = 0; k < W; k++) begin
        taps_o[k] <= run_i && low_zero(cnt_next, k);
      end
    end
  end

endmodule // pcm_prescaler

// ---- sim/pcm_far_model.sv ----
`timescale 1ns/100ps

// Stands for the generic clock controller and the reset pin pad.
module pcm_far_model #(
  parameter int READY_DLY = 60
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Pin control from the bench
  input wire logic pin_low_i,
  // Far side outputs
  output logic main_clk_ready_o,
  output logic reset_pin_b_o
);
  int cnt_reg;

  // The main clock is reported ready only after a start-up delay.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= 0;
    end else if (cnt_reg < READY_DLY) begin
      cnt_reg <= cnt_reg + 1;
    end
  end
  assign main_clk_ready_o = (cnt_reg >= READY_DLY);

  // The pad has a pull-up, so an undriven pin reads high.
  assign reset_pin_b_o = pin_low_i ? 1'b0 : 1'b1;
endmodule // pcm_far_model

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
`include "pcm_cfg.svh"
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected %s expected %0h seen %0h", n, e, a); end end

module tb_top;
  logic clk_i = 0, rst_b_i = 0, reg_we_i = 0, reg_re_i = 0, irq_o;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, ahb_pe, apba_pe, apbb_pe, apbc_pe;
  logic cpu_en, ahb_en, rdy, pin_b, pin_low = 0, bod_c = 0, bod_i = 0, wdt = 0, sw = 0;
  logic [2:0] apb_en;
  logic pwr_r, dbg_r, sys_r, wait_for_interrupt_instr = 0, deep = 0, w_as = 0, w_apb = 0, w_ahb = 0, reg_lp, src_stop;
  int fail_count = 0, n_checks = 0;

  always #2.5 clk_i = ~clk_i;

  pcm_far_model pcm_far_model_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .pin_low_i(pin_low),
    .main_clk_ready_o(rdy), .reset_pin_b_o(pin_b));

  pcm_top pcm_top_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .cpu_clk_en_o(cpu_en), .ahb_clk_en_o(ahb_en),
    .apb_clk_en_o(apb_en), .ahb_periph_en_o(ahb_pe), .apba_periph_en_o(apba_pe),
    .apbb_periph_en_o(apbb_pe), .apbc_periph_en_o(apbc_pe), .main_clk_ready_i(rdy),
    .core_brownout_reset_i(bod_c), .io_brownout_reset_i(bod_i), .reset_pin_b_i(pin_b),
    .watchdog_reset_i(wdt), .cpu_software_reset_request_i(sw), .power_reset_o(pwr_r),
    .debug_reset_o(dbg_r), .system_reset_o(sys_r), .wait_for_interrupt_instr_i(wait_for_interrupt_instr),
    .cpu_deep_sleep_bit_i(deep), .wake_async_i(w_as), .wake_apb_i(w_apb), .wake_ahb_i(w_ahb),
    .regulator_low_power_o(reg_lp), .clock_sources_stop_o(src_stop));

  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task tmo;
    fail_count++;
    $display("unexpected wait_bound expected 0 seen 1");
    stop_test;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task cnt(input int n, output int c, output int a, output int p);
    c = 0;
    a = 0;
    p = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      c += (cpu_en === 1'b1);
      a += (ahb_en === 1'b1);
      p += (apb_en[0] === 1'b1);
    end
    // Return on an edge so that callers drive their next inputs there.
    @(posedge clk_i);
  endtask

  task pulse_wfi;
    @(posedge clk_i);
    wait_for_interrupt_instr <= 1'b1;
    @(posedge clk_i);
    wait_for_interrupt_instr <= 1'b0;
  endtask

  // Waits for the reset outputs to fall and the CPU strobe to start.
  task wait_up;
    int i;
    for (i = 0; i < 400 && sys_r !== 1'b0; i++) @(posedge clk_i);
    if (i == 400) tmo;
    for (i = 0; i < 400 && cpu_en !== 1'b1; i++) @(posedge clk_i);
    if (i == 400) tmo;
  endtask

  task t_defaults;
    logic [31:0] d;
    rd(`PCM_OFS_AHBMASK, d); `CHK("ahbmask", `PCM_RST_AHBMASK, d)
    rd(`PCM_OFS_APBAMASK, d); `CHK("apbamask", `PCM_RST_APBAMASK, d)
    rd(`PCM_OFS_APBBMASK, d); `CHK("apbbmask", `PCM_RST_APBBMASK, d)
    rd(`PCM_OFS_APBCMASK, d); `CHK("apbcmask", `PCM_RST_APBCMASK, d)
    rd(`PCM_OFS_RESET_CAUSE_REG, d); `CHK("cause", {24'h0, `PCM_CAUSE_POR}, d)
    rd(`PCM_OFS_CPU_CLOCK_SELECT, d); `CHK("cpu_clock_select", 32'h0, d)
    `CHK("ahb_pe", `PCM_RST_AHBMASK, ahb_pe)
    `CHK("apba_pe", `PCM_RST_APBAMASK, apba_pe)
    wr(`PCM_OFS_APBCMASK, 32'h00000001);
    #1 `CHK("apbc_pe", 32'h00000001, apbc_pe)
  endtask

  task t_idle(input int lvl);
    int c, a, p;
    wr(`PCM_OFS_SLEEP, lvl);
    pulse_wfi;
    cnt(16, c, a, p);
    `CHK("idle_cpu", 0, c)
    `CHK("idle_ahb", (lvl == 0) ? 16 : 0, a)
    `CHK("idle_apb", (lvl < 2) ? 16 : 0, p)
    // A source of a weaker level must leave the CPU stopped.
    w_ahb <= (lvl == 1);
    w_apb <= (lvl == 2);
    cnt(8, c, a, p);
    `CHK("no_wake", 0, c)
    w_ahb <= (lvl == 0);
    w_apb <= (lvl == 1);
    w_as <= (lvl == 2);
    repeat (6) @(posedge clk_i);
    {w_ahb, w_apb, w_as} <= 3'b000;
    cnt(8, c, a, p);
    `CHK("wake_cpu", 8, c)
  endtask

  task t_standby;
    int c, a, p;
    deep <= 1'b1;
    pulse_wfi;
    cnt(8, c, a, p);
    `CHK("stby_clk", 0, c + a + p)
    `CHK("stby_reg", 1'b1, reg_lp)
    `CHK("stby_src", 1'b1, src_stop)
    w_apb <= 1'b1;
    cnt(8, c, a, p);
    `CHK("stby_hold", 0, c)
    w_as <= 1'b1;
    repeat (6) @(posedge clk_i);
    {w_apb, w_as, deep} <= 3'b000;
    cnt(8, c, a, p);
    `CHK("stby_wake", 8, c)
    `CHK("stby_reg_off", 1'b0, reg_lp)
  endtask

  task t_divider;
    logic [31:0] d;
    int i, s, c, a, p;
    wr(`PCM_OFS_INTERRUPT_ENABLE_SET_REG, 32'h1);
    // Steps: unchanged CPU select, APB A halved, then CPU halved, so the CPU is never slower than APB A.
    for (s = 0; s < 3; s++) begin
      wr((s == 1) ? 8'h09 : `PCM_OFS_CPU_CLOCK_SELECT, (s == 0) ? 32'h0 : 32'h1);
      #1 `CHK("irq_low", 1'b0, irq_o)
      rd(`PCM_OFS_INTERRUPT_FLAG_REG, d);
      // The first step is not aligned to the common tick, so its flag may already be back.
      if (s > 0) `CHK("clock_ready_flag_low", 1'b0, d[0])
      // The select is not written again before the flag returns.
      for (i = 0; i < 200 && d[0] !== 1'b1; i++) rd(`PCM_OFS_INTERRUPT_FLAG_REG, d);
      if (i == 200) tmo;
      `CHK("irq_high", 1'b1, irq_o)
      cnt(64, c, a, p);
      `CHK("cpu_rate", (s == 2) ? 32 : 64, c)
      `CHK("ahb_rate", (s == 2) ? 32 : 64, a)
      `CHK("apb_rate", (s == 0) ? 64 : 32, p)
    end
    wr(`PCM_OFS_INTERRUPT_FLAG_REG, 32'h1);
    #1 `CHK("irq_clr", 1'b0, irq_o)
  endtask

  task t_lock;
    logic [31:0] d;
    wr(`PCM_OFS_APBAMASK, 32'h0000007d);
    wr(`PCM_OFS_APBBMASK, 32'h0);
    #1 `CHK("locked_pe", `PCM_RST_APBBMASK, apbb_pe)
    rd(`PCM_OFS_APBBMASK, d); `CHK("locked_rd", 32'h0, d)
  endtask

  task t_resets;
    logic [31:0] d;
    logic [7:0] ec;
    int k;
    for (k = 0; k < 5; k++) begin
      @(posedge clk_i);
      case (k)
        0: begin bod_c <= 1'b1; ec = `PCM_CAUSE_BOD_CORE; end
        1: begin bod_i <= 1'b1; ec = `PCM_CAUSE_BOD_IO; end
        2: begin pin_low <= 1'b1; ec = `PCM_CAUSE_EXT; end
        3: begin wdt <= 1'b1; ec = `PCM_CAUSE_WDT; end
        default: begin sw <= 1'b1; ec = `PCM_CAUSE_SW; end
      endcase
      repeat (5) @(posedge clk_i);
      {bod_c, bod_i, pin_low, wdt, sw} <= 5'b00000;
      #1 `CHK("sys_rst", 1'b1, sys_r)
      `CHK("pwr_rst", k < 2, pwr_r)
      `CHK("dbg_rst", k < 3, dbg_r)
      wait_up;
      rd(`PCM_OFS_RESET_CAUSE_REG, d); `CHK("cause", {24'h0, ec}, d)
      rd(`PCM_OFS_APBAMASK, d); `CHK("unlock", `PCM_RST_APBAMASK, d)
    end
  endtask

  initial begin
    int c, a, p;
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (c = 0; c < 400 && sys_r !== 1'b0; c++) @(posedge clk_i);
    if (c == 400) tmo;
    cnt(8, c, a, p);
    `CHK("boot_cpu", 0, c)
    wait_up;
    t_defaults;
    for (int l = 0; l < 3; l++) t_idle(l);
    t_standby;
    t_divider;
    t_lock;
    t_resets;
    stop_test;
  end
endmodule // tb_top
